// [phy_diag_status_irq_regs.sv]
// The implementer's own choice: register access over AHB-Lite.
`include "phy_diag_params.svh"

module phy_diag_status_irq_regs
   import phy_diag_pkg::*;
#(
   parameter int unsigned DIAG_TIMEOUT_CYC = `DIAG_TIMEOUT_US * `CLK_MHZ
)
(
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // ahb-lite slave
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   output logic              hreadyout,
   output logic              hresp,
   output logic [31:0]       hrdata,
   // cable measurement engine
   output logic              diag_start,
   output logic              diag_abort,
   output logic [1:0]        diag_pair,
   input  wire logic         diag_done,
   input  wire diag_result_t diag_result,
   // phy line side status and events
   input  wire logic         link_1000_up,
   input  wire logic         link_100_up,
   input  wire logic         port_link_up,
   input  wire logic         rx_symbol_error_frame,
   input  wire phy_events_t  phy_events,
   // interrupts
   output logic              port_irq,
   output logic              irq
);

   function automatic reg_sel_t reg_decode(input logic [31:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (addr[31:14] == 18'h00000)
      begin
         case (addr[13:0])
            {`REG_IDX_CABLE_DIAG, 2'b00}: sel = SEL_CABLE_DIAG;
            {`REG_IDX_PCS_LINK, 2'b00}:   sel = SEL_PCS_LINK;
            {`REG_IDX_RXSE_COUNT, 2'b00}: sel = SEL_RXSE_COUNT;
            {`REG_IDX_EVENTS, 2'b00}:     sel = SEL_EVENTS;
            {`REG_IDX_IRQ_STATUS, 2'b00}: sel = SEL_IRQ_STATUS;
            {`REG_IDX_IRQ_MASK, 2'b00}:   sel = SEL_IRQ_MASK;
            default:                      sel = SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // bus phase tracking
   logic         addr_ok;
   reg_sel_t     sel_q;
   logic         wr_q;
   logic         rd_wait_q;
   logic [31:0]  hrdata_q;
   logic         wr_en;
   logic         rd_en;
   logic [15:0]  wdata;

   // register state
   diag_state_t  diag_state_q;
   logic         diag_rsvd14_q;
   logic [1:0]   diag_rsvd_q;
   logic [1:0]   diag_pair_q;
   logic [1:0]   diag_stat_q;
   logic [7:0]   diag_dist_q;
   logic [31:0]  diag_timer_q;
   logic         diag_start_q;
   logic         diag_abort_q;
   logic         diag_fin;
   logic         diag_timeout;
   logic [15:0]  rxse_count_q;
   logic         count_wrap;
   logic [7:0]   evt_en_q;
   logic [7:0]   evt_flag_q;
   logic [7:0]   evt_vec;
   logic         link_up_q;
   logic [2:0]   irq_stat_q;
   logic [2:0]   irq_mask_q;
   logic [2:0]   irq_set;
   logic [2:0]   irq_clr;
   logic [15:0]  rd_value;

   assign addr_ok = hsel && hready &&
      (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);

   // reads take one wait state so that the read-clear side effects and the
   // returned data happen in the same cycle, after any earlier write landed
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_q     <= SEL_NONE;
         wr_q      <= 1'b0;
         rd_wait_q <= 1'b0;
      end
      else
      begin
         if (rd_wait_q)
            rd_wait_q <= 1'b0;
         else if (hready)
         begin
            wr_q      <= addr_ok && hwrite;
            rd_wait_q <= addr_ok && !hwrite;
            sel_q     <= addr_ok ? reg_decode(haddr) : SEL_NONE;
         end
      end
   end

   assign wr_en = wr_q;
   assign rd_en = rd_wait_q;
   assign wdata = hwdata[15:0];

   assign hreadyout = !rd_wait_q;
   assign hresp     = `HRESP_OKAY;
   assign hrdata    = hrdata_q;

   always_comb
   begin
      rd_value = 16'h0000;
      case (sel_q)
         SEL_CABLE_DIAG:
         begin
            rd_value[`DIAG_EN_BIT] = (diag_state_q == DIAG_RUN); // RULE2
            rd_value[`DIAG_RSVD14_BIT] = diag_rsvd14_q;
            rd_value[`DIAG_PAIR_HI:`DIAG_PAIR_LO] = diag_pair_q;
            rd_value[`DIAG_RSVD_HI:`DIAG_RSVD_LO] = diag_rsvd_q;
            rd_value[`DIAG_STAT_HI:`DIAG_STAT_LO] = diag_stat_q; // RULE4
            rd_value[`DIAG_DIST_HI:`DIAG_DIST_LO] = diag_dist_q; // RULE5
         end
         SEL_PCS_LINK:
         begin
            rd_value[`PCS_1000_BIT] = link_1000_up; // RULE6
            rd_value[`PCS_100_BIT]  = link_100_up;  // RULE7
         end
         SEL_RXSE_COUNT: rd_value = rxse_count_q; // RULE8
         SEL_EVENTS:     rd_value = {evt_en_q, evt_flag_q}; // RULE9 RULE10
         SEL_IRQ_STATUS: rd_value[`IRQ_MSB:0] = irq_stat_q;
         SEL_IRQ_MASK:   rd_value[`IRQ_MSB:0] = irq_mask_q;
         default:        rd_value = 16'h0000;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         hrdata_q <= 32'h00000000;
      else if (rd_en)
         hrdata_q <= {16'h0000, rd_value};
   end

   // cable test control; a write of zero while running aborts the test
   assign diag_timeout = (diag_state_q == DIAG_RUN) &&
      (diag_timer_q == DIAG_TIMEOUT_CYC - 1);
   assign diag_fin = (diag_state_q == DIAG_RUN) && (diag_done || diag_timeout);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_state_q <= DIAG_IDLE;
         diag_start_q <= 1'b0;
         diag_abort_q <= 1'b0;
         diag_timer_q <= 32'h00000000;
      end
      else
      begin
         diag_start_q <= 1'b0;
         diag_abort_q <= 1'b0;
         case (diag_state_q)
            DIAG_IDLE:
            begin
               diag_timer_q <= 32'h00000000;
               if (wr_en && sel_q == SEL_CABLE_DIAG && wdata[`DIAG_EN_BIT])
               begin
                  diag_state_q <= DIAG_RUN; // RULE1
                  diag_start_q <= 1'b1;
               end
            end
            DIAG_RUN:
            begin
               diag_timer_q <= diag_timer_q + 32'h00000001;
               if (diag_fin)
               begin
                  diag_state_q <= DIAG_IDLE; // RULE1
               end
               else if (wr_en && sel_q == SEL_CABLE_DIAG &&
                        !wdata[`DIAG_EN_BIT])
               begin
                  diag_state_q <= DIAG_IDLE; // RULE1
                  diag_abort_q <= 1'b1;
               end
            end
            default:
            begin
               diag_state_q <= DIAG_IDLE;
            end
         endcase
      end
   end

   // pair select is frozen while a test runs so the engine sees one pair
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_pair_q   <= `DIAG_PAIR_RST;
         diag_rsvd14_q <= 1'b0;
         diag_rsvd_q   <= 2'h0;
      end
      else if (wr_en && sel_q == SEL_CABLE_DIAG && diag_state_q == DIAG_IDLE)
      begin
         diag_pair_q   <= wdata[`DIAG_PAIR_HI:`DIAG_PAIR_LO]; // RULE3
         diag_rsvd14_q <= wdata[`DIAG_RSVD14_BIT];
         diag_rsvd_q   <= wdata[`DIAG_RSVD_HI:`DIAG_RSVD_LO];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_stat_q <= `DIAG_STAT_RST;
         diag_dist_q <= `DIAG_DIST_RST;
      end
      else if (diag_fin)
      begin
         if (diag_done)
         begin
            diag_stat_q <= diag_result.status;   // RULE4
            diag_dist_q <= diag_result.distance; // RULE5
         end
         else
         begin
            diag_stat_q <= `DIAG_STAT_FAILED; // RULE4
            diag_dist_q <= `DIAG_DIST_RST;
         end
      end
   end

   assign diag_start = diag_start_q;
   assign diag_abort = diag_abort_q;
   assign diag_pair  = diag_pair_q; // RULE3

   // counter wraps rather than saturating; the wrap raises an irq bit
   assign count_wrap = rx_symbol_error_frame && (rxse_count_q == `COUNT_MAX);

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         rxse_count_q <= `COUNT_RST;
      else if (rd_en && sel_q == SEL_RXSE_COUNT)
      begin
         // a frame counted in the read cycle survives the clear
         rxse_count_q <= rx_symbol_error_frame ? 16'h0001 : `COUNT_RST; // RULE8
      end
      else if (rx_symbol_error_frame)
         rxse_count_q <= rxse_count_q + 16'h0001; // RULE8
   end

   // link edges feed the up and down flags
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         link_up_q <= 1'b0;
      else
         link_up_q <= port_link_up;
   end

   assign evt_vec = {phy_events.jabber, phy_events.rx_error,
                     phy_events.page_rx, phy_events.pd_fault,
                     phy_events.lp_ack,
                     link_up_q && !port_link_up, // RULE12
                     phy_events.remote_fault,
                     !link_up_q && port_link_up}; // RULE12

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         evt_en_q <= `EVT_EN_RST;
      else if (wr_en && sel_q == SEL_EVENTS)
         evt_en_q <= wdata[`EVT_EN_MSB:`EVT_EN_LSB]; // RULE9
   end

   generate
      for (genvar i = 0; i < `EVT_COUNT; i++)
      begin : g_flag
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               evt_flag_q[i] <= 1'b0;
            else if (evt_vec[i])
               evt_flag_q[i] <= 1'b1; // RULE10 RULE14
            else if (rd_en && sel_q == SEL_EVENTS)
               evt_flag_q[i] <= 1'b0; // RULE11
         end
      end
   endgenerate

   assign port_irq = |(evt_flag_q & evt_en_q); // RULE13

   // block-level interrupt: sticky, write one to clear, set wins
   assign irq_set = {count_wrap, |evt_vec, diag_fin};
   assign irq_clr = (wr_en && sel_q == SEL_IRQ_STATUS) ?
      wdata[`IRQ_MSB:0] : `IRQ_RST;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_stat_q <= `IRQ_RST;
      else
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_mask_q <= `IRQ_RST;
      else if (wr_en && sel_q == SEL_IRQ_MASK)
         irq_mask_q <= wdata[`IRQ_MSB:0];
   end

   assign irq = |(irq_stat_q & irq_mask_q);

endmodule

// [phy_diag_params.svh]
`ifndef PHY_DIAG_PARAMS_SVH
`define PHY_DIAG_PARAMS_SVH
// Notes on behaviour
// (RULE1) writing one to bit 15 starts a cable test; hardware clears it at end
// (RULE2) bit 15 reads one while testing, zero when result fields are valid
// (RULE3) bits 13:12 pick pair A to D under test, reset 00
// (RULE4) bits 9:8 report normal, open, short or failed, reset 00
// (RULE5) bits 7:0 give fault distance for open or short results
// (RULE6) pcs status bit 1 follows the gigabit link state
// (RULE7) pcs status bit 0 follows the 100 Mbit link state
// (RULE8) 16-bit counter counts frames with symbol errors, reset zero, read clears
// (RULE9) upper interrupt byte holds eight read-write enables, reset zero
// (RULE10) lower interrupt byte holds eight read-only event flags, reset zero
// (RULE11) reading the interrupt register clears every event flag; here a flag whose event fires in the read cycle stays set
// (RULE12) link down flag sets on link loss, link up flag on link gain
// (RULE13) port interrupt is high while any flag meets its enable
// (RULE14) flags latch whatever the enables say; enables gate only the output

// register indices; byte address is four times the index
`define REG_IDX_CABLE_DIAG   12'h124
`define REG_IDX_PCS_LINK     12'h126
`define REG_IDX_RXSE_COUNT   12'h12a
`define REG_IDX_EVENTS       12'h136
`define REG_IDX_IRQ_STATUS   12'h140
`define REG_IDX_IRQ_MASK     12'h141

`define DIAG_EN_BIT          15
`define DIAG_RSVD14_BIT      14
`define DIAG_PAIR_HI         13
`define DIAG_PAIR_LO         12
`define DIAG_RSVD_HI         11
`define DIAG_RSVD_LO         10
`define DIAG_STAT_HI         9
`define DIAG_STAT_LO         8
`define DIAG_DIST_HI         7
`define DIAG_DIST_LO         0
`define DIAG_PAIR_RST        2'h0
`define DIAG_STAT_RST        2'h0
`define DIAG_DIST_RST        8'h00
`define DIAG_STAT_FAILED     2'h3

`define PCS_1000_BIT         1
`define PCS_100_BIT          0

`define COUNT_RST            16'h0000
`define COUNT_MAX            16'hffff
`define EVT_COUNT            8
`define EVT_EN_MSB           15
`define EVT_EN_LSB           8
`define EVT_FLAG_RST         8'h00
`define EVT_EN_RST           8'h00

`define IRQ_DIAG_DONE_BIT    0
`define IRQ_PORT_EVENT_BIT   1
`define IRQ_COUNT_WRAP_BIT   2
`define IRQ_RST              3'h0
`define IRQ_MSB              2

`define CLK_MHZ              250
`define DIAG_TIMEOUT_US      100

`define HTRANS_NONSEQ        2'h2
`define HTRANS_SEQ           2'h3
`define HRESP_OKAY           1'h0
`endif

// [phy_diag_pkg.sv]
package phy_diag_pkg;

   typedef enum logic [0:0] {
      DIAG_IDLE = 1'b0,
      DIAG_RUN  = 1'b1
   } diag_state_t;

   typedef enum logic [2:0] {
      SEL_NONE       = 3'b000,
      SEL_CABLE_DIAG = 3'b001,
      SEL_PCS_LINK   = 3'b010,
      SEL_RXSE_COUNT = 3'b011,
      SEL_EVENTS     = 3'b100,
      SEL_IRQ_STATUS = 3'b101,
      SEL_IRQ_MASK   = 3'b110
   } reg_sel_t;

   // outcome handed back by the analog cable measurement
   typedef struct packed {
      logic [1:0] status;
      logic [7:0] distance;
   } diag_result_t;

   // one-cycle event pulses from the phy line logic
   typedef struct packed {
      logic jabber;
      logic rx_error;
      logic page_rx;
      logic pd_fault;
      logic lp_ack;
      logic remote_fault;
   } phy_events_t;

endpackage

// [phy_diag_asserts.sv]
module phy_diag_asserts
(
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   input  wire logic        diag_start,
   input  wire logic        diag_abort,
   input  wire logic [1:0]  diag_pair,
   input  wire logic        link_1000_up,
   input  wire logic        link_100_up,
   input  wire logic        port_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take;
   logic wr_diag;

   assign take = hsel && hready && htrans[1];
   assign wr_diag = take && hwrite && haddr == 32'h490;

   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // a read always spends one wait cycle before its data
   sequence s_rd_phase;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_rd_pcs;
      take && !hwrite && haddr == 32'h498 ##1 s_rd_phase;
   endsequence

   a_start_cause: assert property (
      diag_start |-> $past(wr_diag, 2) && $past(hwdata[15]))
      else $error("test start without a start write");
   a_start_single: assert property (
      diag_start |=> !diag_start)
      else $error("test start longer than one cycle");
   a_abort_cause: assert property (
      diag_abort |-> $past(wr_diag, 2) && !$past(hwdata[15]))
      else $error("abort without a stop write");
   a_pair_follows: assert property (
      diag_start |-> diag_pair == $past(hwdata[13:12]))
      else $error("pair under test differs from written pair");
   a_link_bits: assert property (
      s_rd_pcs |-> hrdata[15:0] ==
         {14'h0, $past(link_1000_up), $past(link_100_up)})
      else $error("link status read wrong");
   a_read_wait: assert property (
      take && !hwrite |=> s_rd_phase)
      else $error("read data phase timing wrong");
   a_write_nowait: assert property (
      take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   a_reset_clean: assert property (
      $rose(rst_n) |-> !diag_start && !diag_abort &&
         diag_pair == 2'h0 && !port_irq)
      else $error("outputs not idle after reset");
endmodule

bind phy_diag_status_irq_regs phy_diag_asserts chk_u (
   .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hreadyout, .hrdata, .diag_start, .diag_abort, .diag_pair,
   .link_1000_up, .link_100_up, .port_irq
);

// [phy_line_model.sv]
module phy_line_model
   import phy_diag_pkg::*;
(
   input  wire logic    sys_clk,
   input  wire logic    rst_n,
   input  wire logic    diag_start,
   input  wire logic    diag_abort,
   output logic         diag_done,
   output diag_result_t diag_result,
   output logic         link_1000_up,
   output logic         link_100_up,
   output logic         port_link_up,
   output logic         rx_symbol_error_frame,
   output phy_events_t  phy_events
);
   timeunit 1ns;
   timeprecision 1ps;
   int           dly = 8;
   int           cnt_q;
   diag_result_t want = '0;

   // result lines carry noise outside the done cycle
   assign diag_result = diag_done ? want : ~want;

   initial
   begin
      link_1000_up = 1'b0;
      link_100_up = 1'b0;
      port_link_up = 1'b0;
      rx_symbol_error_frame = 1'b0;
      phy_events = '0;
   end

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 0;
         diag_done <= 1'b0;
      end
      else
      begin
         diag_done <= cnt_q == 1;
         if (diag_start)
            cnt_q <= dly;
         else if (diag_abort || cnt_q == 1)
            cnt_q <= 0;
         else if (cnt_q > 1)
            cnt_q <= cnt_q - 1;
      end
   end

   // one-cycle pulse, then an idle cycle so calls can follow directly
   task pulse(input phy_events_t e, input logic f);
      phy_events <= e;
      rx_symbol_error_frame <= f;
      @(posedge sys_clk);
      phy_events <= '0;
      rx_symbol_error_frame <= 1'b0;
      @(posedge sys_clk);
   endtask
endmodule

// [tb.sv]
module tb
   import phy_diag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ALL = 32'hffffffff;
   logic         sys_clk = 1'b0;
   logic         rst_n = 1'b0;
   logic         hsel = 1'b0;
   logic         hwrite = 1'b0;
   logic [31:0]  haddr = 32'h0;
   logic [31:0]  hwdata = 32'h0;
   logic [1:0]   htrans = 2'h0;
   logic [2:0]   hsize = 3'h2;
   logic [31:0]  r;
   wire          hready;
   wire          hreadyout;
   wire          hresp;
   wire [31:0]   hrdata;
   wire          diag_start;
   wire          diag_abort;
   wire [1:0]    diag_pair;
   wire          diag_done;
   diag_result_t diag_result;
   wire          link_1000_up;
   wire          link_100_up;
   wire          port_link_up;
   wire          rx_symbol_error_frame;
   phy_events_t  phy_events;
   wire          port_irq;
   wire          irq;
   int           n_mismatch = 0;
   int           check_count = 0;
   int           cyc = 0;
   int           i;

   assign hready = hreadyout;
   always #2 sys_clk = ~sys_clk;

   phy_diag_status_irq_regs #(.DIAG_TIMEOUT_CYC(50)) dut_u (
      .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .diag_start, .diag_abort,
      .diag_pair, .diag_done, .diag_result, .link_1000_up, .link_100_up,
      .port_link_up, .rx_symbol_error_frame, .phy_events, .port_irq, .irq
   );

   phy_line_model line_u (
      .sys_clk, .rst_n, .diag_start, .diag_abort, .diag_done, .diag_result,
      .link_1000_up, .link_100_up, .port_link_up, .rx_symbol_error_frame,
      .phy_events
   );

   task summarize;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         n_mismatch++;
      end
   endtask

   // entered just after a rising edge; holds each phase until hready
   task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hready !== 1'b1);
      r = hrdata;
   endtask

   task rd_chk(input string n, input logic [31:0] a, e, m);
      xfer(a, 1'b0, 32'h0);
      chk(n, e, r & m);
   endtask

   // poll until the test-enable bit reads back clear
   task wait_idle;
      for (int k = 0; k < 100; k++)
      begin
         xfer(32'h490, 1'b0, 32'h0);
         if (r[15] === 1'b0)
            break;
      end
   endtask

   task link_step(input logic v);
      line_u.port_link_up <= v;
      repeat (3) @(posedge sys_clk);
   endtask

   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      rd_chk("diag reset", 32'h490, 32'h0, ALL);
      rd_chk("count reset", 32'h4a8, 32'h0, ALL);
      rd_chk("event reset", 32'h4d8, 32'h0, ALL);
      rd_chk("unmapped", 32'h600, 32'h0, ALL);
      chk("okay", 32'h0, hresp);
      for (i = 0; i < 4; i++)
      begin
         line_u.link_1000_up <= i[1];
         line_u.link_100_up <= i[0];
         @(posedge sys_clk);
         rd_chk("pcs link", 32'h498, i, ALL);
      end
      repeat (3) line_u.pulse('0, 1'b1);
      rd_chk("count", 32'h4a8, 32'h3, ALL);
      rd_chk("count cleared", 32'h4a8, 32'h0, ALL);
      for (i = 0; i < 6; i++)
         line_u.pulse(6'h1 << i, 1'b0);
      link_step(1'b1);
      link_step(1'b0);
      chk("irq gated", 32'h0, port_irq);
      rd_chk("all flags", 32'h4d8, 32'hff, ALL);
      rd_chk("flags cleared", 32'h4d8, 32'h0, ALL);
      xfer(32'h4d8, 1'b1, 32'hffff);
      rd_chk("enables", 32'h4d8, 32'hff00, ALL);
      xfer(32'h4d8, 1'b1, 32'h0400);
      line_u.pulse(6'h20, 1'b0);
      link_step(1'b1);
      chk("irq other", 32'h0, port_irq);
      link_step(1'b0);
      chk("irq down", 32'h1, port_irq);
      rd_chk("down flags", 32'h4d8, 32'h0485, ALL);
      chk("irq after read", 32'h0, port_irq);
      // a silent engine must end as test failed with zero distance
      line_u.dly <= 200;
      xfer(32'h490, 1'b1, 32'h8000);
      wait_idle();
      chk("timeout", 32'h0300, r & ALL);
      line_u.dly <= 8;
      for (i = 0; i < 4; i++)
      begin
         line_u.want <= {i[1:0], 8'h20 + i[7:0]};
         xfer(32'h490, 1'b1, 32'h8000 | (i << 12));
         rd_chk("busy", 32'h490, 32'h8000 | (i << 12), 32'hb000);
         chk("pair out", i, diag_pair);
         wait_idle();
         chk("result", (i << 12) | (i << 8) | ((i == 1 || i == 2) ?
            32'h20 + i : 0), r & ((i == 1 || i == 2) ? ALL : 32'hff00));
      end
      line_u.dly <= 40;
      xfer(32'h490, 1'b1, 32'h8000);
      @(posedge sys_clk);
      chk("start pulse", 32'h1, diag_start);
      xfer(32'h490, 1'b1, 32'h0);
      @(posedge sys_clk);
      chk("abort pulse", 32'h1, diag_abort);
      rd_chk("abort", 32'h490, 32'h0300, 32'h8300);
      rd_chk("irq status", 32'h500, 32'h1, 32'h1);
      chk("irq masked", 32'h0, irq);
      xfer(32'h504, 1'b1, 32'h1);
      @(posedge sys_clk);
      chk("irq on", 32'h1, irq);
      xfer(32'h500, 1'b1, 32'h1);
      @(posedge sys_clk);
      chk("irq off", 32'h0, irq);
      summarize();
   end
endmodule
